// ===== design/mpg_output_gate.sv
// Output master enable, level select, toggle and brushless gate logic for channels 3 and 4.
`timescale 1ns/10ps
`default_nettype none
module mpg_output_gate (
	input wire logic clk_sys, // Timer clock, 40 MHz.
	input wire logic nrst, // Power-on reset, asynchronous, active low.
	input wire logic ce, // Clock enable; all state holds while low.
	input wire logic standby, // Standby entry; reinitialises the registers.
	input wire logic [mpg_pkg::MPG_AW-1:0] reg_addr, // Halfword register index.
	input wire logic reg_wr, // Write strobe.
	input wire logic reg_rd, // Read strobe.
	input wire logic [1:0] reg_be, // Byte lanes: bit 1 upper byte, bit 0 lower.
	input wire logic [mpg_pkg::MPG_DW-1:0] reg_wdata, // Write data.
	output logic [mpg_pkg::MPG_DW-1:0] reg_rdata, // Read data, one cycle after strobe.
	input wire logic pwm_mode, // High in complementary or reset-synchronised PWM mode.
	input wire logic [mpg_pkg::MPG_PH-1:0] pwm_pos_on, // Positive phase active, {W,V,U}.
	input wire logic [mpg_pkg::MPG_PH-1:0] pwm_neg_on, // Negative phase active, {W,V,U}.
	input wire logic dt_elapsed, // Dead time after count start has passed.
	input wire logic period_tick, // One-cycle pulse at each PWM period.
	input wire logic [mpg_pkg::MPG_PINS-1:0] ord_out, // Ordinary-mode pin levels.
	input wire logic [mpg_pkg::MPG_PH-1:0] fb_in, // Capture feedback pins, {W,V,U}.
	output logic [mpg_pkg::MPG_PINS-1:0] pin_out, // Pin levels.
	output logic [mpg_pkg::MPG_PINS-1:0] pin_oe, // Pin drive enables, high drives.
	output logic toggle_out // Period-synchronous toggle output.
);
	import mpg_pkg::*;

	mpg_fb_if fb_link ();

	mpg_fb_sync u_fb_sync (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.ce(ce),
		.fb(fb_link.sync)
	);

	assign fb_link.raw = fb_in;

	// Register file.
	logic [7:0] output_master_enable, output_control, gate_control;
	logic [7:0] next_output_master_enable, next_output_control, next_gate_control;
	logic [MPG_DW-1:0] next_reg_rdata;
	logic [7:0] wr_hi, wr_lo;
	logic [7:0] rd_hi, rd_lo;

	assign wr_hi = reg_wdata[MPG_DW-1:8];
	assign wr_lo = reg_wdata[7:0];

	always_comb begin
		next_output_master_enable = output_master_enable;
		next_output_control = output_control;
		next_gate_control = gate_control;
		next_reg_rdata = reg_rdata;
		rd_hi = 8'h00;
		rd_lo = 8'h00;
		unique case (reg_addr)
			MPG_IDX_OUT: begin
				rd_hi = output_master_enable;
				rd_lo = output_control;
			end
			MPG_IDX_GATE: begin
				rd_hi = gate_control;
			end
			default: begin
				rd_hi = 8'h00;
			end
		endcase
		if (ce) begin
			if (standby) begin
				next_output_master_enable = MPG_OME_RST;
				next_output_control = MPG_OC_RST;
				next_gate_control = MPG_GC_RST;
			end else if (reg_wr) begin
				// Either byte lane may be written alone, or both in one 16-bit access.
				if (reg_addr == MPG_IDX_OUT && reg_be[MPG_LANE_HI]) begin
					next_output_master_enable = mpg_merge(wr_hi, MPG_OME_WMASK, MPG_OME_FIXED);
				end
				if (reg_addr == MPG_IDX_OUT && reg_be[MPG_LANE_LO]) begin
					next_output_control = mpg_merge(wr_lo, MPG_OC_WMASK, MPG_OC_FIXED);
				end
				if (reg_addr == MPG_IDX_GATE && reg_be[MPG_LANE_HI]) begin
					next_gate_control = mpg_merge(wr_hi, MPG_GC_WMASK, MPG_GC_FIXED);
				end
			end
			if (reg_rd) begin
				next_reg_rdata = {reg_be[MPG_LANE_HI] ? rd_hi : 8'h00,
					reg_be[MPG_LANE_LO] ? rd_lo : 8'h00};
			end
		end
	end

	// Only power-on reset and standby touch these; a manual reset is not wired in at all.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			output_master_enable <= MPG_OME_RST;
			output_control <= MPG_OC_RST;
			gate_control <= MPG_GC_RST;
			reg_rdata <= MPG_RD_RST;
		end else begin
			output_master_enable <= next_output_master_enable;
			output_control <= next_output_control;
			gate_control <= next_gate_control;
			reg_rdata <= next_reg_rdata;
		end
	end

	// Field views.
	logic period_toggle_enable, neg_level_select, pos_level_select;
	logic brushless_select, neg_chop_select, pos_chop_select, feedback_source_select;
	mpg_phase_t phase_switch;

	assign period_toggle_enable = output_control[MPG_OC_TOGGLE_EN];
	assign neg_level_select = output_control[MPG_OC_NEG_LVL];
	assign pos_level_select = output_control[MPG_OC_POS_LVL];
	assign brushless_select = gate_control[MPG_GC_BRUSHLESS];
	assign neg_chop_select = gate_control[MPG_GC_NCHOP];
	assign pos_chop_select = gate_control[MPG_GC_PCHOP];
	assign feedback_source_select = gate_control[MPG_GC_FB];
	assign phase_switch = gate_control[MPG_GC_PHASE_HI:0];

	// Pin generation.
	mpg_phase_t fb_code, pos_on, neg_on, neg_pwm;
	mpg_pins_t gate_on;
	mpg_pins_t next_pin_out, next_pin_oe;
	logic next_toggle_out;

	always_comb begin
		fb_code = feedback_source_select ? phase_switch : fb_link.stable;
		gate_on = mpg_phase_decode(fb_code);
		// Before the dead time has run the negative phase stays at its initial level, except in brushless mode with negative chop off.
		neg_pwm = pwm_neg_on & {MPG_PH{dt_elapsed}};
		pos_on = pwm_pos_on;
		neg_on = neg_pwm;
		if (brushless_select) begin
			pos_on = pos_chop_select ? (gate_on[MPG_PH-1:0] & pwm_pos_on)
				: gate_on[MPG_PH-1:0];
			neg_on = neg_chop_select ? (gate_on[MPG_PINS-1:MPG_PH] & neg_pwm)
				: gate_on[MPG_PINS-1:MPG_PH];
		end
		next_pin_out = pin_out;
		next_pin_oe = pin_oe;
		next_toggle_out = toggle_out;
		if (ce) begin
			next_pin_oe = output_master_enable[MPG_PINS-1:0];
			if (pwm_mode) begin
				next_pin_out = {mpg_level(neg_on, neg_level_select),
					mpg_level(pos_on, pos_level_select)};
			end else begin
				next_pin_out = ord_out;
			end
			if (!(pwm_mode && period_toggle_enable)) begin
				next_toggle_out = 1'b0;
			end else if (period_tick) begin
				next_toggle_out = ~toggle_out;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pin_out <= MPG_PIN_RST;
			pin_oe <= MPG_PIN_RST;
			toggle_out <= 1'b0;
		end else begin
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
			toggle_out <= next_toggle_out;
		end
	end

	// Checks. The caller must set the enables before the pin controls; nothing here can see that.
	default clocking mpg_cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	pin_enable_a: assert property ($past(ce) |-> pin_oe == $past(output_master_enable[MPG_PINS-1:0]))
		else $error("pin enables do not follow the master enable bits");

	standby_init_a: assert property (ce && standby |=> output_master_enable == MPG_OME_RST
		&& output_control == MPG_OC_RST && gate_control == MPG_GC_RST)
		else $error("standby did not reinitialise the registers");

	ome_fixed_a: assert property (ce && reg_rd && reg_addr == MPG_IDX_OUT
		&& reg_be[MPG_LANE_HI] |=> reg_rdata[MPG_DW-1:MPG_DW-2] == 2'h3)
		else $error("master enable fixed bits did not read as one");

	gc_fixed_a: assert property (ce && reg_rd && reg_addr == MPG_IDX_GATE
		&& reg_be[MPG_LANE_HI] |=> reg_rdata[MPG_DW-1])
		else $error("gate control bit 7 did not read as one");

	oc_write_a: assert property (ce && !standby && reg_wr && reg_addr == MPG_IDX_OUT
		&& reg_be[MPG_LANE_LO] |=> output_control == ($past(reg_wdata[7:0]) & MPG_OC_WMASK))
		else $error("output control write not stored");

	ord_pass_a: assert property (ce && !pwm_mode |=> pin_out == $past(ord_out))
		else $error("settings affected pins outside the PWM modes");

	toggle_off_a: assert property (ce && !period_toggle_enable |=> !toggle_out)
		else $error("toggle output active while disabled");

	toggle_flip_a: assert property (ce && pwm_mode && period_toggle_enable && period_tick
		|=> toggle_out != $past(toggle_out))
		else $error("toggle output did not flip on a period pulse");

	neg_initial_a: assert property (ce && pwm_mode && !brushless_select && !dt_elapsed
		|=> pin_out[MPG_PINS-1:MPG_PH] == {MPG_PH{~$past(neg_level_select)}})
		else $error("negative pins left initial level before dead time");

	pos_level_a: assert property (ce && pwm_mode && !brushless_select
		|=> pin_out[MPG_PH-1:0] == mpg_level($past(pwm_pos_on), $past(pos_level_select)))
		else $error("positive pin level select wrong");

	gate_direct_a: assert property (ce && pwm_mode && brushless_select && feedback_source_select
		&& !pos_chop_select && !neg_chop_select && !neg_level_select && !pos_level_select
		|=> pin_out == ~mpg_phase_decode($past(phase_switch)))
		else $error("gate decode wrong for register feedback");

	chop_and_a: assert property (ce && pwm_mode && brushless_select && pos_chop_select
		&& pos_level_select |=> pin_out[MPG_PH-1:0]
		== ($past(gate_on[MPG_PH-1:0]) & $past(pwm_pos_on)))
		else $error("positive chop is not gate and PWM");

	freeze_a: assert property (!ce |=> $stable(pin_out) && $stable(pin_oe) && $stable(toggle_out)
		&& $stable(gate_control))
		else $error("state moved while clock enable low");

	bdc_ext_c: cover property (ce && pwm_mode && brushless_select && !feedback_source_select
		&& fb_link.stable == 3'h5);
	toggle_c: cover property (ce && pwm_mode && period_toggle_enable && period_tick);
	both_lane_c: cover property (ce && reg_wr && reg_be == 2'h3 && reg_addr == MPG_IDX_OUT);
	chop_neg_c: cover property (ce && pwm_mode && brushless_select && neg_chop_select
		&& dt_elapsed);
endmodule : mpg_output_gate
`default_nettype wire

// ===== design/mpg_pkg.sv
// Constants, field layouts and decode helpers for the motor PWM output gating block.
`default_nettype none
package mpg_pkg;
	localparam int unsigned MPG_DW = 16;
	localparam int unsigned MPG_AW = 2;
	localparam int unsigned MPG_PH = 3;
	localparam int unsigned MPG_PINS = 6;
	localparam int unsigned MPG_SYNC_STAGES = 3;
	localparam logic [MPG_AW-1:0] MPG_IDX_OUT = 2'h0;
	localparam logic [MPG_AW-1:0] MPG_IDX_GATE = 2'h1;
	localparam int unsigned MPG_LANE_HI = 1;
	localparam int unsigned MPG_LANE_LO = 0;
	localparam logic [7:0] MPG_OME_RST = 8'hC0;
	localparam logic [7:0] MPG_OME_FIXED = 8'hC0;
	localparam logic [7:0] MPG_OME_WMASK = 8'h3F;
	localparam logic [7:0] MPG_OC_RST = 8'h00;
	localparam logic [7:0] MPG_OC_FIXED = 8'h00;
	localparam logic [7:0] MPG_OC_WMASK = 8'h43;
	localparam logic [7:0] MPG_GC_RST = 8'h80;
	localparam logic [7:0] MPG_GC_FIXED = 8'h80;
	localparam logic [7:0] MPG_GC_WMASK = 8'h7F;
	localparam int unsigned MPG_OC_TOGGLE_EN = 6;
	localparam int unsigned MPG_OC_NEG_LVL = 1;
	localparam int unsigned MPG_OC_POS_LVL = 0;
	localparam int unsigned MPG_GC_BRUSHLESS = 6;
	localparam int unsigned MPG_GC_NCHOP = 5;
	localparam int unsigned MPG_GC_PCHOP = 4;
	localparam int unsigned MPG_GC_FB = 3;
	localparam int unsigned MPG_GC_PHASE_HI = 2;
	localparam logic [MPG_PINS-1:0] MPG_PIN_RST = 6'h00;
	localparam logic [MPG_DW-1:0] MPG_RD_RST = 16'h0000;

	typedef logic [MPG_PH-1:0] mpg_phase_t;
	typedef logic [MPG_PINS-1:0] mpg_pins_t;

	// Result order: {w_neg, v_neg, u_neg, w_pos, v_pos, u_pos}; code order is {W, V, U}.
	function automatic mpg_pins_t mpg_phase_decode(input mpg_phase_t code);
		mpg_pins_t r;
		r = 6'h00;
		unique case (code)
			3'h1: r = 6'h21;
			3'h2: r = 6'h0A;
			3'h3: r = 6'h22;
			3'h4: r = 6'h14;
			3'h5: r = 6'h11;
			3'h6: r = 6'h0C;
			default: r = 6'h00;
		endcase
		return r;
	endfunction : mpg_phase_decode

	// Level select 0 means active low, so an inactive (or initial) phase sits high.
	function automatic mpg_phase_t mpg_level(input mpg_phase_t on, input logic ols);
		return ols ? on : ~on;
	endfunction : mpg_level

	// Byte-lane merge for an 8-bit register; fixed bits are forced whatever is written.
	function automatic logic [7:0] mpg_merge(input logic [7:0] data, input logic [7:0] wmask,
			input logic [7:0] fixed);
		return (data & wmask) | fixed;
	endfunction : mpg_merge
endpackage : mpg_pkg
`default_nettype wire

// ===== design/mpg_fb_if.sv
// Carrier between the gating core and the feedback synchroniser.
`timescale 1ns/10ps
`default_nettype none
interface mpg_fb_if;
	import mpg_pkg::*;
	mpg_phase_t raw;
	mpg_phase_t stable;
	modport core(output raw, input stable);
	modport sync(input raw, output stable);
endinterface : mpg_fb_if
`default_nettype wire

// ===== design/mpg_fb_sync.sv
// Three-stage synchroniser with agreement filter for the capture feedback inputs.
`timescale 1ns/10ps
`default_nettype none
module mpg_fb_sync (
	input wire logic clk_sys, // Timer clock.
	input wire logic nrst, // Asynchronous reset, active low.
	input wire logic ce, // Clock enable; state holds while low.
	mpg_fb_if.sync fb // Raw pins in, filtered phases out.
);
	import mpg_pkg::*;

	mpg_phase_t s1, s2, s3, stable;
	mpg_phase_t next_s1, next_s2, next_s3, next_stable;

	always_comb begin
		next_s1 = s1;
		next_s2 = s2;
		next_s3 = s3;
		next_stable = stable;
		if (ce) begin
			next_s1 = fb.raw;
			next_s2 = s1;
			next_s3 = s2;
			// Only a level seen in two successive samples is accepted, so one glitch is dropped.
			if (s2 == s3) begin
				next_stable = s3;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			stable <= '0;
		end else begin
			s1 <= next_s1;
			s2 <= next_s2;
			s3 <= next_s3;
			stable <= next_stable;
		end
	end

	assign fb.stable = stable;

	sync_agree_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		(stable != $past(stable)) |-> ($past(s2) == $past(s3)) && (stable == $past(s3)))
		else $error("feedback accepted without two agreeing samples");
endmodule : mpg_fb_sync
`default_nettype wire

// ===== dv/mpg_gate_drv_model.sv
// Behavioural model of the three-phase gate driver inputs on the six gated pins.
`timescale 1ns/10ps
`default_nettype none
module mpg_gate_drv_model (
	input wire logic [5:0] pin_out, // Levels from the timer.
	input wire logic [5:0] pin_oe, // Drive enables from the timer.
	output logic [5:0] gate_in // Levels the driver sees.
);
	// Driver inputs carry pull-downs, so a released pin reads low and never a stale level.
	always_comb begin
		gate_in = pin_out & pin_oe;
	end
endmodule : mpg_gate_drv_model
`default_nettype wire

// ===== dv/motor_pwm_output_gating_tb_top.sv
// Self-checking bench for the motor PWM output gating block.
`timescale 1ns/10ps
`default_nettype none
module motor_pwm_output_gating_tb_top;
	import mpg_pkg::*;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	logic standby = 1'b0;
	logic [MPG_AW-1:0] reg_addr = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [1:0] reg_be = 2'h0;
	logic [MPG_DW-1:0] reg_wdata = '0;
	logic [MPG_DW-1:0] reg_rdata;
	logic pwm_mode = 1'b0;
	mpg_phase_t pwm_pos_on = '0;
	mpg_phase_t pwm_neg_on = '0;
	logic dt_elapsed = 1'b0;
	logic period_tick = 1'b0;
	mpg_pins_t ord_out = '0;
	mpg_phase_t fb_in = '0;
	mpg_pins_t pin_out;
	mpg_pins_t pin_oe;
	mpg_pins_t gate_in;
	logic toggle_out;
	mpg_pins_t held_pins;
	int n_mismatch = 0;
	int checked = 0;
	int cycles = 0;
	logic [7:0] ome = 8'hC0;
	logic [7:0] oc = 8'h00;
	logic [7:0] gc = 8'h80;
	logic [5:0] dec [8] = '{6'h00, 6'h21, 6'h0A, 6'h22, 6'h14, 6'h11, 6'h0C, 6'h00};

	mpg_output_gate dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .standby(standby),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_be(reg_be),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pwm_mode(pwm_mode),
		.pwm_pos_on(pwm_pos_on), .pwm_neg_on(pwm_neg_on), .dt_elapsed(dt_elapsed),
		.period_tick(period_tick), .ord_out(ord_out), .fb_in(fb_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .toggle_out(toggle_out));
	mpg_gate_drv_model drv (.pin_out(pin_out), .pin_oe(pin_oe), .gate_in(gate_in));

	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic give_verdict();
		if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask : tick

	// Reads are compared against the bench's own copy of the registers.
	task automatic access(input logic wr, input logic [1:0] a, input logic [1:0] be,
			input logic [15:0] d);
		logic [15:0] q;
		reg_addr = a;
		reg_be = be;
		reg_wdata = d;
		reg_wr = wr;
		reg_rd = !wr;
		tick(1);
		q = reg_rdata;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		if (wr && a == 2'h0 && be[1]) ome = (d[15:8] & 8'h3F) | 8'hC0;
		if (wr && a == 2'h0 && be[0]) oc = d[7:0] & 8'h43;
		if (wr && a == 2'h1 && be[1]) gc = (d[15:8] & 8'h7F) | 8'h80;
		if (!wr && a == 2'h0) chk(q, {be[1] ? ome : 8'h00, be[0] ? oc : 8'h00});
		if (!wr && a == 2'h1) chk(q, {be[1] ? gc : 8'h00, 8'h00});
		if (!wr && a[1]) chk(q, 16'h0000);
		tick(1);
	endtask : access

	function automatic logic [5:0] exp_pins();
		logic [2:0] p;
		logic [2:0] n;
		logic [5:0] g;
		if (!pwm_mode) return ord_out;
		p = pwm_pos_on;
		n = pwm_neg_on & {3{dt_elapsed}};
		g = dec[gc[3] ? gc[2:0] : fb_in];
		if (gc[6]) p = gc[4] ? g[2:0] & p : g[2:0];
		if (gc[6]) n = gc[5] ? g[5:3] & n : g[5:3];
		return {oc[1] ? n : ~n, oc[0] ? p : ~p};
	endfunction : exp_pins

	initial begin
		void'($urandom(55096));
		repeat (12) @(posedge clk_sys);
		#2;
		nrst = 1'b1;
		tick(1);
		for (int a = 0; a < 4; a++) access(1'b0, 2'(a), 2'h3, 16'h0000);
		access(1'b1, 2'h0, 2'h3, 16'hFFFF);
		access(1'b1, 2'h1, 2'h3, 16'h8000);
		access(1'b1, 2'h2, 2'h3, 16'h0000);
		for (int a = 0; a < 3; a++) access(1'b0, 2'(a), 2'h3, 16'h0000);
		access(1'b1, 2'h0, 2'h1, 16'hFF00);
		access(1'b0, 2'h0, 2'h2, 16'h0000);
		access(1'b0, 2'h0, 2'h3, 16'h0000);
		for (int i = 0; i < 64; i++) begin
			// Enables go in before the phase controls, as software is obliged to do.
			access(1'b1, 2'h0, 2'h3, {2'h3, 6'($urandom()), 8'($urandom())});
			access(1'b1, 2'h1, 2'h2, {1'b1, 4'($urandom()), 3'(i), 8'h00});
			pwm_mode = 1'($urandom());
			pwm_pos_on = 3'($urandom());
			pwm_neg_on = 3'($urandom());
			dt_elapsed = 1'($urandom());
			ord_out = 6'($urandom());
			fb_in = 3'($urandom());
			tick(8);
			chk(16'(pin_out), 16'(exp_pins()));
			chk(16'(pin_oe), 16'(ome[5:0]));
			chk(16'(gate_in), 16'(ome[5:0] & exp_pins()));
			chk(16'(toggle_out), 16'h0000);
		end
		pwm_mode = 1'b1;
		access(1'b1, 2'h0, 2'h3, 16'hFF40);
		for (int i = 1; i < 6; i++) begin
			period_tick = 1'b1;
			tick(1);
			period_tick = 1'b0;
			tick(2);
			chk(16'(toggle_out), 16'(i & 1));
		end
		access(1'b1, 2'h0, 2'h3, 16'hFF00);
		chk(16'(toggle_out), 16'h0000);
		access(1'b1, 2'h0, 2'h3, 16'hFF40);
		pwm_mode = 1'b0;
		period_tick = 1'b1;
		tick(1);
		period_tick = 1'b0;
		tick(2);
		chk(16'(toggle_out), 16'h0000);
		access(1'b1, 2'h1, 2'h2, 16'hFF00);
		// A low clock enable must hold every flop, even against a write and a period pulse.
		held_pins = exp_pins();
		ce = 1'b0;
		reg_addr = 2'h0;
		reg_be = 2'h3;
		reg_wdata = 16'hC000;
		reg_wr = 1'b1;
		pwm_mode = 1'b1;
		period_tick = 1'b1;
		ord_out = 6'($urandom());
		fb_in = 3'($urandom());
		tick(3);
		chk(16'(pin_out), 16'(held_pins));
		chk(16'(pin_oe), 16'(ome[5:0]));
		chk(16'(toggle_out), 16'h0000);
		reg_wr = 1'b0;
		period_tick = 1'b0;
		ce = 1'b1;
		tick(1);
		access(1'b0, 2'h0, 2'h3, 16'h0000);
		standby = 1'b1;
		tick(1);
		standby = 1'b0;
		ome = 8'hC0;
		oc = 8'h00;
		gc = 8'h80;
		tick(2);
		chk(16'(pin_oe), 16'h0000);
		for (int a = 0; a < 2; a++) access(1'b0, 2'(a), 2'h3, 16'h0000);
		give_verdict();
	end
endmodule : motor_pwm_output_gating_tb_top
`default_nettype wire
